// File: ecw_pkg.sv
// Constants, types and helpers shared by the extended configuration window slice
// Functional notes
// R1: Index bits 7:2 give the dword register number of each indirect access.
// R2: Index bits 11:8 give the extended register number, joined with the dword number.
// R3: Reading the window data register returns the register the index selects.
// R4: Writing the window data register updates the register the index selects.
// R5: Byte enables of the data register access apply to the selected register.
// R6: Index pointing at the data register: reads give zero, writes are dropped.
// R7: Index pointing at itself: writes through the data register change the index.
// R8: Data register reads over SMBus give zero; SMBus writes have no effect.
// R9: Header: identifier 0x1 in 15:0, version 0x1 in 19:16, lockable pointer 0x200.
// R10: Flag bit 0 has no function; sticky write-one-to-clear, resets to zero.
// R11: Flag bit 4 sets on link protocol error; software clears by writing one.
// R12: Flag bit 5 sets on surprise down only while surprise_down_capable is set.
// R13: Flag bit 12 sets on poisoned TLP, bit 13 on credit protocol error.
// R14: Flag bits 14 and 15 are hardwired read-only zero.
// R15: Flag bit 16 sets on unexpected completion, bit 17 on receiver overflow.
// R16: Flag bits 18, 19, 20 set on malformed TLP, ECRC error, unsupported request.
// R17: Flag bit 21, access control violation, is hardwired to zero.
// R18: Bit 31 sets on memory double-bit error when enabled; else reads zero, read-only.
// R19: Flags survive non-power-on resets, clear only by written ones; reserved bits zero. The code also clears bit 31 while double_bit_report_enable is low.
package ecw_pkg;

  // Byte offsets of the registers in this slice
  localparam logic [11:0] ECW_OFS_INDEX = 12'h0F8;
  localparam logic [11:0] ECW_OFS_DATA  = 12'h0FC;
  localparam logic [11:0] ECW_OFS_CAP   = 12'h100;
  localparam logic [11:0] ECW_OFS_FLAGS = 12'h104;

  // Same offsets as dword numbers, the form used on the request ports
  localparam logic [9:0] ECW_DW_INDEX = ECW_OFS_INDEX[11:2];
  localparam logic [9:0] ECW_DW_DATA  = ECW_OFS_DATA[11:2];
  localparam logic [9:0] ECW_DW_CAP   = ECW_OFS_CAP[11:2];
  localparam logic [9:0] ECW_DW_FLAGS = ECW_OFS_FLAGS[11:2];

  // Index register fields
  localparam int unsigned ECW_IDX_REG_LSB  = 2;
  localparam int unsigned ECW_IDX_REG_MSB  = 7;
  localparam int unsigned ECW_IDX_EXTENDED_INDEX_LSB = 8;
  localparam int unsigned ECW_IDX_EXTENDED_INDEX_MSB = 11;
  localparam logic [9:0]  ECW_INDEX_RST    = 10'h000;

  // Capability header fields and values
  localparam int unsigned ECW_CAP_VER_LSB = 16;
  localparam int unsigned ECW_CAP_PTR_LSB = 20;
  localparam logic [15:0] ECW_CAP_ID      = 16'h0001;
  localparam logic [3:0]  ECW_CAP_VER     = 4'h1;
  localparam logic [11:0] ECW_NEXT_PTR_RST = 12'h200;

  // Uncorrectable flag bit positions
  localparam int unsigned ECW_FB_UNUSED     = 0;
  localparam int unsigned ECW_FB_LINK_PROTO = 4;
  localparam int unsigned ECW_FB_SURPRISE   = 5;
  localparam int unsigned ECW_FB_POISONED   = 12;
  localparam int unsigned ECW_FB_CREDIT     = 13;
  localparam int unsigned ECW_FB_UNEXP_CPL  = 16;
  localparam int unsigned ECW_FB_RX_OVFL    = 17;
  localparam int unsigned ECW_FB_BAD_FORMAT = 18;
  localparam int unsigned ECW_FB_ECRC       = 19;
  localparam int unsigned ECW_FB_UNSUP_REQ  = 20;
  localparam int unsigned ECW_FB_DOUBLE_BIT = 31;
  // Bits that can ever hold a one, plus unused bit 0, which never sets; all others read zero
  localparam logic [31:0] ECW_FLAG_LIVE_MASK = 32'h801F3031;
  localparam logic [31:0] ECW_FLAGS_RST      = 32'h00000000;

  typedef enum logic [1:0] {
    ECW_IDLE = 2'b00,
    ECW_FWD  = 2'b01
  } ecw_state_e;

  // Expand four byte enables into a 32-bit lane mask
  function automatic logic [31:0] ecw_be_mask(input logic [3:0] be);
    ecw_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : ecw_be_mask

  // Replace only the enabled bytes of a word
  function automatic logic [31:0] ecw_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  be);
    logic [31:0] m;
    m = ecw_be_mask(be);
    ecw_merge = (old_w & ~m) | (new_w & m);
  endfunction : ecw_merge

endpackage : ecw_pkg

// File: ecw_flag_reg.sv
// Sticky uncorrectable error flags with write-one-to-clear
`timescale 1ns/10ps
module ecw_flag_reg (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ev_link_protocol,
  input  wire logic        ev_surprise_down,
  input  wire logic        ev_poisoned,
  input  wire logic        ev_credit_protocol,
  input  wire logic        ev_unexpected_completion,
  input  wire logic        ev_receiver_overflow,
  input  wire logic        ev_bad_format,
  input  wire logic        ev_ecrc,
  input  wire logic        ev_unsupported_request,
  input  wire logic        ev_double_bit,
  input  wire logic        surprise_down_capable,
  input  wire logic        double_bit_report_enable,
  input  wire logic        clr_we,
  input  wire logic [31:0] clr_data,
  input  wire logic [3:0]  clr_be,
  output logic      [31:0] flags
);

  typedef struct packed {
    logic [31:0] flags;
  } ecw_flag_s;

  ecw_flag_s r;
  ecw_flag_s n;
  logic [31:0] set_v;
  logic [31:0] clr_v;

  always_comb begin
    set_v = '0;
    set_v[ecw_pkg::ECW_FB_LINK_PROTO] = ev_link_protocol;                            // [R11]
    set_v[ecw_pkg::ECW_FB_SURPRISE]   = ev_surprise_down & surprise_down_capable;    // [R12]
    set_v[ecw_pkg::ECW_FB_POISONED]   = ev_poisoned;                                 // [R13]
    set_v[ecw_pkg::ECW_FB_CREDIT]     = ev_credit_protocol;                          // [R13]
    set_v[ecw_pkg::ECW_FB_UNEXP_CPL]  = ev_unexpected_completion;                    // [R15]
    set_v[ecw_pkg::ECW_FB_RX_OVFL]    = ev_receiver_overflow;                        // [R15]
    set_v[ecw_pkg::ECW_FB_BAD_FORMAT] = ev_bad_format;                               // [R16]
    set_v[ecw_pkg::ECW_FB_ECRC]       = ev_ecrc;                                     // [R16]
    set_v[ecw_pkg::ECW_FB_UNSUP_REQ]  = ev_unsupported_request;                      // [R16]
    set_v[ecw_pkg::ECW_FB_DOUBLE_BIT] = ev_double_bit & double_bit_report_enable;    // [R18]
    clr_v = clr_we ? (clr_data & ecw_pkg::ecw_be_mask(clr_be)) : '0;
    n = r;
    // A new event in the clearing cycle keeps the flag set
    n.flags = ((r.flags & ~clr_v) | set_v) & ecw_pkg::ECW_FLAG_LIVE_MASK;           // [R10] [R14] [R17] [R19]
    if (!double_bit_report_enable) begin
      n.flags[ecw_pkg::ECW_FB_DOUBLE_BIT] = 1'b0;                                    // [R18]
    end
  end

  // Only power-on reset reaches these flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r.flags <= ecw_pkg::ECW_FLAGS_RST;                                             // [R19]
    end else begin
      r <= n;
    end
  end

  assign flags = r.flags;

endmodule : ecw_flag_reg

// File: ecw_cap_hdr.sv
// Error reporting capability header with lockable next pointer
`timescale 1ns/10ps
module ecw_cap_hdr (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        next_ptr_lock,
  input  wire logic        we,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  be,
  output logic      [31:0] header
);

  typedef struct packed {
    logic [11:0] next_ptr;
  } ecw_cap_s;

  ecw_cap_s    r;
  ecw_cap_s    n;
  logic [31:0] merged;

  always_comb begin
    n = r;
    merged = ecw_pkg::ecw_merge(header, wdata, be);
    // Locked pointer ignores writes
    if (we && !next_ptr_lock) begin
      n.next_ptr = merged[31:ecw_pkg::ECW_CAP_PTR_LSB];                              // [R9]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r.next_ptr <= ecw_pkg::ECW_NEXT_PTR_RST;                                       // [R9]
    end else begin
      r <= n;
    end
  end

  assign header = {r.next_ptr, ecw_pkg::ECW_CAP_VER, ecw_pkg::ECW_CAP_ID};           // [R9]

endmodule : ecw_cap_hdr

// File: ecw_ext_cfg_window.sv
// Extended configuration access window and error reporting status slice
`timescale 1ns/10ps
module ecw_ext_cfg_window (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hot_rst,
  input  wire logic        cfg_req,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_smbus,
  input  wire logic [9:0]  cfg_dw_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic             cfg_ready,
  output logic             cfg_ack,
  output logic      [31:0] cfg_rdata,
  output logic             tgt_req,
  output logic             tgt_wr,
  output logic      [9:0]  tgt_dw_addr,
  output logic      [3:0]  tgt_be,
  output logic      [31:0] tgt_wdata,
  input  wire logic        tgt_ack,
  input  wire logic [31:0] tgt_rdata,
  input  wire logic        next_ptr_lock,
  input  wire logic        surprise_down_capable,
  input  wire logic        double_bit_report_enable,
  input  wire logic        ev_link_protocol,
  input  wire logic        ev_surprise_down,
  input  wire logic        ev_poisoned,
  input  wire logic        ev_credit_protocol,
  input  wire logic        ev_unexpected_completion,
  input  wire logic        ev_receiver_overflow,
  input  wire logic        ev_bad_format,
  input  wire logic        ev_ecrc,
  input  wire logic        ev_unsupported_request,
  input  wire logic        ev_double_bit,
  output logic      [31:0] uncorrectable_error_flags
);

  typedef struct packed {
    ecw_pkg::ecw_state_e state;
    logic [9:0]          index;
    logic                ack;
    logic [31:0]         rdata;
    logic                tgt_req;
    logic                tgt_wr;
    logic [9:0]          tgt_dw_addr;
    logic [3:0]          tgt_be;
    logic [31:0]         tgt_wdata;
  } ecw_win_s;

  ecw_win_s    r;
  ecw_win_s    n;
  logic        lw_en;
  logic [9:0]  lw_dw;
  logic [9:0]  sel_dw;
  logic [31:0] idx_word;
  logic [31:0] idx_merged;
  logic [31:0] cap_header;
  logic [31:0] flags_word;
  logic        cap_we;
  logic        flag_we;

  // Registers answered inside this slice
  function automatic logic is_local(input logic [9:0] dw);
    is_local = (dw == ecw_pkg::ECW_DW_INDEX) || (dw == ecw_pkg::ECW_DW_DATA) ||
               (dw == ecw_pkg::ECW_DW_CAP) || (dw == ecw_pkg::ECW_DW_FLAGS);
  endfunction : is_local

  // Read value of a local register; the data register itself reads zero
  function automatic logic [31:0] local_rd(input logic [9:0]  dw,
                                           input logic [31:0] idx_w,
                                           input logic [31:0] cap_w,
                                           input logic [31:0] flg_w);
    if (dw == ecw_pkg::ECW_DW_INDEX) begin
      local_rd = idx_w;
    end else if (dw == ecw_pkg::ECW_DW_CAP) begin
      local_rd = cap_w;
    end else if (dw == ecw_pkg::ECW_DW_FLAGS) begin
      local_rd = flg_w;
    end else begin
      local_rd = '0;
    end
  endfunction : local_rd

  // Index word as software sees it; bits 1:0 and 31:12 read zero
  assign idx_word = {20'h00000, r.index, 2'b00};

  always_comb begin
    n          = r;
    n.ack      = 1'b0;
    lw_en      = 1'b0;
    lw_dw      = cfg_dw_addr;
    // Register number and extended register number form the target dword
    sel_dw     = {r.index[ecw_pkg::ECW_IDX_EXTENDED_INDEX_MSB - 2:ecw_pkg::ECW_IDX_EXTENDED_INDEX_LSB - 2],
                  r.index[ecw_pkg::ECW_IDX_REG_MSB - 2:ecw_pkg::ECW_IDX_REG_LSB - 2]};   // [R1] [R2]
    idx_merged = ecw_pkg::ecw_merge(idx_word, cfg_wdata, cfg_be);
    case (r.state)
      ecw_pkg::ECW_IDLE: begin
        if (cfg_req) begin
          if (cfg_dw_addr == ecw_pkg::ECW_DW_DATA) begin
            if (cfg_smbus) begin
              n.ack   = 1'b1;
              n.rdata = '0;                                                          // [R8]
            end else if (sel_dw == ecw_pkg::ECW_DW_DATA) begin
              n.ack   = 1'b1;
              n.rdata = '0;                                                          // [R6]
            end else if (is_local(sel_dw)) begin
              // Indirect access landing on a register of this slice
              n.ack   = 1'b1;
              lw_en   = cfg_wr;                                                      // [R4] [R7]
              lw_dw   = sel_dw;
              n.rdata = cfg_wr ? '0 :
                        (local_rd(sel_dw, idx_word, cap_header, flags_word) &
                         ecw_pkg::ecw_be_mask(cfg_be));                              // [R3] [R5]
            end else begin
              // Hand the access to the rest of configuration space
              n.tgt_req     = 1'b1;
              n.tgt_wr      = cfg_wr;                                                // [R4]
              n.tgt_dw_addr = sel_dw;                                                // [R1] [R2]
              n.tgt_be      = cfg_be;                                                // [R5]
              n.tgt_wdata   = cfg_wdata;
              n.state       = ecw_pkg::ECW_FWD;
            end
          end else if (is_local(cfg_dw_addr)) begin
            n.ack   = 1'b1;
            lw_en   = cfg_wr;
            lw_dw   = cfg_dw_addr;
            n.rdata = cfg_wr ? '0 :
                      (local_rd(cfg_dw_addr, idx_word, cap_header, flags_word) &
                       ecw_pkg::ecw_be_mask(cfg_be));
          end else begin
            // Outside this slice: read zero, write dropped
            n.ack   = 1'b1;
            n.rdata = '0;
          end
        end
      end
      ecw_pkg::ECW_FWD: begin
        if (tgt_ack) begin
          n.tgt_req = 1'b0;
          n.ack     = 1'b1;
          n.rdata   = r.tgt_wr ? '0 : (tgt_rdata & ecw_pkg::ecw_be_mask(r.tgt_be));  // [R3] [R5]
          n.state   = ecw_pkg::ECW_IDLE;
        end
      end
      default: begin
        n.tgt_req = 1'b0;
        n.state   = ecw_pkg::ECW_IDLE;
      end
    endcase
    if (lw_en && (lw_dw == ecw_pkg::ECW_DW_INDEX)) begin
      n.index = idx_merged[ecw_pkg::ECW_IDX_EXTENDED_INDEX_MSB:ecw_pkg::ECW_IDX_REG_LSB];     // [R7] [R5]
    end
    // Hot reset clears the non-sticky index only
    if (hot_rst) begin
      n.index = ecw_pkg::ECW_INDEX_RST;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r.state       <= ecw_pkg::ECW_IDLE;
      r.index       <= ecw_pkg::ECW_INDEX_RST;
      r.ack         <= 1'b0;
      r.rdata       <= 32'h00000000;
      r.tgt_req     <= 1'b0;
      r.tgt_wr      <= 1'b0;
      r.tgt_dw_addr <= 10'h000;
      r.tgt_be      <= 4'h0;
      r.tgt_wdata   <= 32'h00000000;
    end else begin
      r <= n;
    end
  end

  assign cap_we  = lw_en && (lw_dw == ecw_pkg::ECW_DW_CAP);
  assign flag_we = lw_en && (lw_dw == ecw_pkg::ECW_DW_FLAGS);

  ecw_cap_hdr u_cap_hdr (
    .clk           (clk),
    .rst           (rst),
    .next_ptr_lock (next_ptr_lock),
    .we            (cap_we),
    .wdata         (cfg_wdata),
    .be            (cfg_be),
    .header        (cap_header)
  );

  ecw_flag_reg u_flag_reg (
    .clk                      (clk),
    .rst                      (rst),
    .ev_link_protocol         (ev_link_protocol),
    .ev_surprise_down         (ev_surprise_down),
    .ev_poisoned              (ev_poisoned),
    .ev_credit_protocol       (ev_credit_protocol),
    .ev_unexpected_completion (ev_unexpected_completion),
    .ev_receiver_overflow     (ev_receiver_overflow),
    .ev_bad_format            (ev_bad_format),
    .ev_ecrc                  (ev_ecrc),
    .ev_unsupported_request   (ev_unsupported_request),
    .ev_double_bit            (ev_double_bit),
    .surprise_down_capable    (surprise_down_capable),
    .double_bit_report_enable (double_bit_report_enable),
    .clr_we                   (flag_we),
    .clr_data                 (cfg_wdata),
    .clr_be                   (cfg_be),
    .flags                    (flags_word)
  );

  assign cfg_ready                 = (r.state == ecw_pkg::ECW_IDLE);
  assign cfg_ack                   = r.ack;
  assign cfg_rdata                 = r.rdata;
  assign tgt_req                   = r.tgt_req;
  assign tgt_wr                    = r.tgt_wr;
  assign tgt_dw_addr               = r.tgt_dw_addr;
  assign tgt_be                    = r.tgt_be;
  assign tgt_wdata                 = r.tgt_wdata;
  assign uncorrectable_error_flags = flags_word;

endmodule : ecw_ext_cfg_window

// File: ecw_ext_cfg_window_assertions.sv
// Concurrent checks on the ports of the extended configuration window slice
`timescale 1ns/10ps
module ecw_ext_cfg_window_chk (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cfg_req,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_smbus,
  input  wire logic [9:0]  cfg_dw_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic        cfg_ready,
  input  wire logic        cfg_ack,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        tgt_req,
  input  wire logic [9:0]  tgt_dw_addr,
  input  wire logic [3:0]  tgt_be,
  input  wire logic [31:0] tgt_wdata,
  input  wire logic        tgt_ack,
  input  wire logic        ev_poisoned,
  input  wire logic        ev_surprise_down,
  input  wire logic        surprise_down_capable,
  input  wire logic        double_bit_report_enable,
  input  wire logic [31:0] uncorrectable_error_flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic take;
  assign take = cfg_req && cfg_ready;

  a_local_ack: assert property (take && cfg_dw_addr != ecw_pkg::ECW_DW_DATA |=> cfg_ack && !tgt_req)
    else $error("local access not answered next cycle");
  a_fwd_cause: assert property ($rose(tgt_req) |-> $past(take && cfg_dw_addr == ecw_pkg::ECW_DW_DATA && !cfg_smbus))
    else $error("forwarded access without window request");
  a_fwd_lanes: assert property ($rose(tgt_req) |-> tgt_be == $past(cfg_be))
    else $error("forwarded byte enables differ from request");
  a_fwd_hold: assert property (tgt_req && !tgt_ack |=> tgt_req && $stable(tgt_dw_addr) && $stable(tgt_wdata))
    else $error("forwarded access changed before answer");
  a_fwd_done: assert property (tgt_req && tgt_ack |=> !tgt_req && cfg_ack && cfg_ready)
    else $error("forwarded access not completed after answer");
  a_smbus_zero: assert property (take && cfg_smbus && !cfg_wr && cfg_dw_addr == ecw_pkg::ECW_DW_DATA
                                 |=> cfg_ack && cfg_rdata == 32'h00000000)
    else $error("sideband window read not zero");
  a_cap_read: assert property (take && !cfg_wr && cfg_dw_addr == ecw_pkg::ECW_DW_CAP && cfg_be == 4'hF
                               |=> cfg_rdata[19:0] == {ecw_pkg::ECW_CAP_VER, ecw_pkg::ECW_CAP_ID})
    else $error("capability identifier or version wrong");
  a_flags_read: assert property (take && !cfg_wr && cfg_dw_addr == ecw_pkg::ECW_DW_FLAGS && cfg_be == 4'hF
                                 |=> cfg_rdata == $past(uncorrectable_error_flags))
    else $error("flag read differs from flag register");
  a_dead_bits: assert property ((uncorrectable_error_flags & ~ecw_pkg::ECW_FLAG_LIVE_MASK) == 32'h00000000)
    else $error("hardwired flag bit set");
  a_poison_set: assert property (ev_poisoned |=> uncorrectable_error_flags[12])
    else $error("poisoned event not recorded");
  a_surprise_gate: assert property ($rose(uncorrectable_error_flags[5])
                                    |-> $past(ev_surprise_down && surprise_down_capable))
    else $error("surprise flag set without capable event");
  a_dbl_off: assert property (!double_bit_report_enable ##1 !double_bit_report_enable
                              |-> !uncorrectable_error_flags[31])
    else $error("double bit flag set while disabled");
  a_clear_cause: assert property (|($past(uncorrectable_error_flags) & ~uncorrectable_error_flags & 32'h7FFFFFFF)
                                  |-> $past(take && cfg_wr && cfg_dw_addr == ecw_pkg::ECW_DW_FLAGS))
    else $error("flag cleared without write");

  c_forward: cover property (tgt_req && tgt_ack);
  c_smbus: cover property (take && cfg_smbus && cfg_dw_addr == ecw_pkg::ECW_DW_DATA);
  c_clear: cover property (take && cfg_wr && cfg_dw_addr == ecw_pkg::ECW_DW_FLAGS);
endmodule : ecw_ext_cfg_window_chk

bind ecw_ext_cfg_window ecw_ext_cfg_window_chk u_chk (
  .clk(clk), .rst(rst), .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_smbus(cfg_smbus),
  .cfg_dw_addr(cfg_dw_addr), .cfg_be(cfg_be), .cfg_ready(cfg_ready), .cfg_ack(cfg_ack),
  .cfg_rdata(cfg_rdata), .tgt_req(tgt_req), .tgt_dw_addr(tgt_dw_addr), .tgt_be(tgt_be),
  .tgt_wdata(tgt_wdata), .tgt_ack(tgt_ack), .ev_poisoned(ev_poisoned),
  .ev_surprise_down(ev_surprise_down), .surprise_down_capable(surprise_down_capable),
  .double_bit_report_enable(double_bit_report_enable),
  .uncorrectable_error_flags(uncorrectable_error_flags));

// File: ecw_cfg_space_model.sv
// Behavioural model of the remaining configuration space behind the window
`timescale 1ns/10ps
module ecw_cfg_space_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  dly,
  input  wire logic        tgt_req,
  input  wire logic        tgt_wr,
  input  wire logic [9:0]  tgt_dw_addr,
  input  wire logic [3:0]  tgt_be,
  input  wire logic [31:0] tgt_wdata,
  output logic             tgt_ack,
  output logic      [31:0] tgt_rdata
);
  logic [31:0] mem [1024];
  logic [3:0]  cnt;
  // Each word starts as a pattern holding its own dword number
  initial for (int a = 0; a < 1024; a++) mem[a] = {16'hA5A5, 6'h00, a[9:0]};
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tgt_ack <= 1'b0;
      tgt_rdata <= 32'h5A5A5A5A;
      cnt <= 4'h0;
    end else if (tgt_ack) begin
      // Data no longer held: show the inverse so stale values never match
      tgt_ack <= 1'b0;
      tgt_rdata <= ~tgt_rdata;
      cnt <= 4'h0;
    end else if (tgt_req && cnt >= dly) begin
      tgt_ack <= 1'b1;
      tgt_rdata <= mem[tgt_dw_addr];
      if (tgt_wr) for (int i = 0; i < 4; i++) if (tgt_be[i]) mem[tgt_dw_addr][8*i+:8] <= tgt_wdata[8*i+:8];
    end else if (tgt_req) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : ecw_cfg_space_model

// File: ecw_ext_cfg_window_tb.sv
// Self-checking testbench for the extended configuration window slice
`timescale 1ns/10ps
module ecw_ext_cfg_window_tb;
  logic        clk, rst, hot_rst, cfg_req, cfg_wr, cfg_smbus, cfg_ready, cfg_ack;
  logic [9:0]  cfg_dw_addr, tgt_dw_addr;
  logic [3:0]  cfg_be, tgt_be, dly;
  logic [31:0] cfg_wdata, cfg_rdata, tgt_wdata, tgt_rdata, flags, rd;
  logic        tgt_req, tgt_wr, tgt_ack, next_ptr_lock, sd_cap, dbl_en;
  logic [9:0]  ev;
  int          n_fail, checks_done;

  ecw_ext_cfg_window dut (.clk(clk), .rst(rst), .hot_rst(hot_rst), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
    .cfg_smbus(cfg_smbus), .cfg_dw_addr(cfg_dw_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_ready(cfg_ready), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .tgt_req(tgt_req), .tgt_wr(tgt_wr),
    .tgt_dw_addr(tgt_dw_addr), .tgt_be(tgt_be), .tgt_wdata(tgt_wdata), .tgt_ack(tgt_ack),
    .tgt_rdata(tgt_rdata), .next_ptr_lock(next_ptr_lock), .surprise_down_capable(sd_cap),
    .double_bit_report_enable(dbl_en), .ev_link_protocol(ev[0]), .ev_surprise_down(ev[1]),
    .ev_poisoned(ev[2]), .ev_credit_protocol(ev[3]), .ev_unexpected_completion(ev[4]),
    .ev_receiver_overflow(ev[5]), .ev_bad_format(ev[6]), .ev_ecrc(ev[7]),
    .ev_unsupported_request(ev[8]), .ev_double_bit(ev[9]), .uncorrectable_error_flags(flags));
  ecw_cfg_space_model partner (.clk(clk), .rst(rst), .dly(dly), .tgt_req(tgt_req), .tgt_wr(tgt_wr),
    .tgt_dw_addr(tgt_dw_addr), .tgt_be(tgt_be), .tgt_wdata(tgt_wdata), .tgt_ack(tgt_ack),
    .tgt_rdata(tgt_rdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // One request: held for the taking edge, then wait up to 40 cycles for the answer
  task acc(input logic wr, input logic sm, input logic [9:0] a, input logic [3:0] be, input logic [31:0] wd);
    int n;
    @(posedge clk);
    #1 {cfg_req, cfg_wr, cfg_smbus, cfg_dw_addr, cfg_be, cfg_wdata} = {1'b1, wr, sm, a, be, wd};
    @(posedge clk);
    #1 cfg_req = 1'b0;
    n = 0;
    while (cfg_ack !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 40) begin
      n_fail++;
      print_verdict();
    end
    rd = cfg_rdata;
  endtask : acc

  task rd_chk(input logic sm, input logic [9:0] a, input logic [3:0] be, input logic [31:0] exp);
    acc(1'b0, sm, a, be, 32'h00000000);
    chk(rd, exp);
  endtask : rd_chk

  task pulse(input logic [9:0] v, input logic h);
    @(posedge clk);
    #1 {ev, hot_rst} = {v, h};
    @(posedge clk);
    #1 {ev, hot_rst} = 11'h000;
  endtask : pulse

  task done(input string name);
    $display("test %s finished", name);
  endtask : done

  initial begin
    {rst, hot_rst, cfg_req, cfg_wr, cfg_smbus, cfg_dw_addr, cfg_be, cfg_wdata} = {3'b100, 48'h0};
    {next_ptr_lock, sd_cap, dbl_en, ev, dly} = {3'b111, 10'h000, 4'h0};
    n_fail = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    rd_chk(1'b0, ecw_pkg::ECW_DW_INDEX, 4'hF, 32'h00000000);
    rd_chk(1'b0, ecw_pkg::ECW_DW_CAP, 4'hF, 32'h20010001);
    rd_chk(1'b0, ecw_pkg::ECW_DW_FLAGS, 4'hF, 32'h00000000);
    rd_chk(1'b0, ecw_pkg::ECW_DW_DATA, 4'hF, 32'hA5A50000);
    rd_chk(1'b0, 10'h000, 4'hF, 32'h00000000);
    done("reset values");
    acc(1'b1, 1'b0, ecw_pkg::ECW_DW_INDEX, 4'hF, 32'hFFFFFFFF);
    rd_chk(1'b0, ecw_pkg::ECW_DW_INDEX, 4'hF, 32'h00000FFC);
    rd_chk(1'b0, ecw_pkg::ECW_DW_DATA, 4'hF, 32'hA5A503FF);
    acc(1'b1, 1'b0, ecw_pkg::ECW_DW_INDEX, 4'hF, 32'h00000A54);
    dly = 4'h5;
    acc(1'b1, 1'b0, ecw_pkg::ECW_DW_DATA, 4'b0101, 32'h12345678);
    rd_chk(1'b0, ecw_pkg::ECW_DW_DATA, 4'hF, 32'hA5340278);
    dly = 4'h0;
    rd_chk(1'b0, ecw_pkg::ECW_DW_DATA, 4'b0011, 32'h00000278);
    acc(1'b1, 1'b0, ecw_pkg::ECW_DW_INDEX, 4'b0001, 32'h00000058);
    rd_chk(1'b0, ecw_pkg::ECW_DW_DATA, 4'hF, 32'hA5A50296);
    rd_chk(1'b1, ecw_pkg::ECW_DW_DATA, 4'hF, 32'h00000000);
    acc(1'b1, 1'b1, ecw_pkg::ECW_DW_DATA, 4'hF, 32'hDEADBEEF);
    rd_chk(1'b0, ecw_pkg::ECW_DW_DATA, 4'hF, 32'hA5A50296);
    done("indirect window");
    acc(1'b1, 1'b0, ecw_pkg::ECW_DW_INDEX, 4'hF, 32'h000000FC);
    rd_chk(1'b0, ecw_pkg::ECW_DW_DATA, 4'hF, 32'h00000000);
    acc(1'b1, 1'b0, ecw_pkg::ECW_DW_DATA, 4'hF, 32'h00000A54);
    rd_chk(1'b0, ecw_pkg::ECW_DW_INDEX, 4'hF, 32'h000000FC);
    acc(1'b1, 1'b0, ecw_pkg::ECW_DW_INDEX, 4'hF, 32'h000000F8);
    acc(1'b1, 1'b0, ecw_pkg::ECW_DW_DATA, 4'hF, 32'h00000A54);
    rd_chk(1'b0, ecw_pkg::ECW_DW_INDEX, 4'hF, 32'h00000A54);
    done("self pointing index");
    acc(1'b1, 1'b0, ecw_pkg::ECW_DW_CAP, 4'hF, 32'hFFFFFFFF);
    rd_chk(1'b0, ecw_pkg::ECW_DW_CAP, 4'hF, 32'h20010001);
    next_ptr_lock = 1'b0;
    acc(1'b1, 1'b0, ecw_pkg::ECW_DW_CAP, 4'b1100, 32'h12300000);
    rd_chk(1'b0, ecw_pkg::ECW_DW_CAP, 4'hF, 32'h12310001);
    done("capability header");
    pulse(10'h3FF, 1'b0);
    chk(flags, 32'h801F3030);
    pulse(10'h000, 1'b1);
    rd_chk(1'b0, ecw_pkg::ECW_DW_FLAGS, 4'hF, 32'h801F3030);
    rd_chk(1'b0, ecw_pkg::ECW_DW_INDEX, 4'hF, 32'h00000000);
    acc(1'b1, 1'b0, ecw_pkg::ECW_DW_FLAGS, 4'hF, 32'h0000D011);
    chk(flags, 32'h801F2020);
    acc(1'b1, 1'b0, ecw_pkg::ECW_DW_FLAGS, 4'b0011, 32'hFFFFFFFF);
    chk(flags, 32'h801F0000);
    {sd_cap, dbl_en} = 2'b00;
    pulse(10'h202, 1'b0);
    chk(flags, 32'h001F0000);
    sd_cap = 1'b1;
    pulse(10'h002, 1'b0);
    rd_chk(1'b0, ecw_pkg::ECW_DW_FLAGS, 4'hF, 32'h001F0020);
    acc(1'b1, 1'b0, ecw_pkg::ECW_DW_FLAGS, 4'hF, 32'hFFFFFFFF);
    chk(flags, 32'h00000000);
    done("error flags");
    print_verdict();
  end
endmodule : ecw_ext_cfg_window_tb
